// ===== include/pie_pkg.sv
// constants, field layouts, register map and state type of the interrupt and event transfer controller
// assumes a single system clock; nothing else
package pie_pkg;
  // node space: trap 16 .. trap 67
  localparam int FIRST_TRAP = 16;
  localparam int LAST_TRAP = 67;
  localparam int NODES = LAST_TRAP - FIRST_TRAP + 1;
  localparam int TRAP_W = 7;
  localparam int IDX_W = 6;
  localparam int LVL_W = 4;
  localparam int CHANS = 8;
  localparam int PTR_W = 16;
  localparam int SEG_W = 8;
  localparam int ADDR_W = 8;
  // trap groups
  localparam int TRAP_TIMER_LO = 32;
  localparam int TRAP_CAPT_LO = 38;
  localparam int TRAP_ADC_LO = 40;
  localparam int TRAP_CCU_LO = 48;
  localparam int TRAP_CAN_LO = 64;
  // shared capture nodes
  localparam int SHARED_A_LO = 18;
  localparam int SHARED_A_HI = 23;
  localparam int SHARED_B_LO = 28;
  localparam int SHARED_B_HI = 31;
  localparam int ALT_W = 10;
  // node control word
  localparam int CTL_W = 16;
  localparam int CTL_LVL_LSB = 0;
  localparam int CTL_XFER_BIT = 4;
  localparam int CTL_CH_LSB = 5;
  localparam int CTL_CH_W = 3;
  localparam int CTL_ALT_BIT = 8;
  localparam int CTL_IE_BIT = 14;
  localparam int CTL_IR_BIT = 15;
  localparam logic [CTL_W-1:0] CTL_MASK = 16'hc1ff;
  localparam logic [CTL_W-1:0] CTL_RST = 16'h0000;
  // channel control word
  localparam int CC_W = 12;
  localparam int CC_CNT_LSB = 0;
  localparam int CC_CNT_W = 8;
  localparam int CC_WORD_BIT = 8;
  localparam int CC_INCS_BIT = 9;
  localparam int CC_INCD_BIT = 10;
  localparam int CC_CONT_BIT = 11;
  // configuration word
  localparam int CFG_W = 3;
  localparam int CFG_VSC_LSB = 0;
  localparam int CFG_VSC_W = 2;
  localparam int CFG_JC_BIT = 2;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
  localparam int VEC_BASE_SHIFT = 2;
  // fast inputs: per pin [5:0] target node, [7:6] edge mode (bit6 rising, bit7 falling)
  localparam int FAST_PINS = 4;
  localparam int FAST_FLD_W = 8;
  localparam int FAST_MODE_LSB = 6;
  // response in cpu clocks
  localparam int RESP_JC_CLK = 7;
  localparam int RESP_NJC_CLK = 11;
  // word addresses
  localparam logic [ADDR_W-1:0] A_NODE0 = 8'h00;
  localparam logic [ADDR_W-1:0] A_SEG = 8'h40;
  localparam logic [ADDR_W-1:0] A_CFG = 8'h41;
  localparam logic [ADDR_W-1:0] A_FAST = 8'h42;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h43;
  localparam logic [ADDR_W-1:0] A_CH0 = 8'h48;
  localparam int CH_STRIDE = 3;
  typedef enum logic [1:0] {ST_IDLE, ST_RESP, ST_OFFER, ST_XFER} pie_state_t;
endpackage

// ===== design/pie_arb.sv
// priority selector over pending nodes
// assumes all inputs come from logic on the same clock
`timescale 1ns/1ps
module pie_arb #(
  parameter int N = 52,
  parameter int LW = 4,
  parameter int IW = 6
) (
  input wire logic [N-1:0] i_pend,
  input wire logic [N-1:0][LW-1:0] i_lvl,
  output logic o_valid,
  output logic [IW-1:0] o_idx,
  output logic [LW-1:0] o_lvl
);
  if (N < 1 || N > (1 << IW)) begin : g_chk
    $error("pie_arb: node count does not fit index width");
  end
  // highest level wins, equal levels go to the lowest node
  always_comb begin
    o_valid = 1'b0;
    o_idx = '0;
    o_lvl = '0;
    for (int i = 0; i < N; i++) begin
      if (i_pend[i] && (!o_valid || i_lvl[i] > o_lvl)) begin
        o_valid = 1'b1;
        o_idx = IW'(i);
        o_lvl = i_lvl[i];
      end
    end
  end
endmodule

// ===== design/pie_edge.sv
// fast external inputs: two-stage synchroniser and programmable edge detect
// assumes pins are asynchronous to i_sys_clk
`timescale 1ns/1ps
module pie_edge #(
  parameter int W = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_pin,
  input wire logic [2*W-1:0] i_mode,
  output logic [W-1:0] o_edge
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } pie_edge_st_t;
  pie_edge_st_t st_r;
  pie_edge_st_t st_nxt;
  always_comb begin
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // mode bit 0 rising, bit 1 falling, both set for either edge
  for (genvar g = 0; g < W; g++) begin : g_pin
    assign o_edge[g] = (i_mode[2*g] & st_r.s2[g] & ~st_r.s3[g]) |
                       (i_mode[2*g+1] & ~st_r.s2[g] & st_r.s3[g]);
  end
endmodule

// ===== design/pie_top.sv
// prioritized interrupt controller with eight-channel event transfer unit, avalon-mm register slave
// assumes peripheral and alternate requests are one-cycle pulses on i_sys_clk; cpu acks on the same clock
//
// Operation
// - request offered 7 or 11 clocks after flag
// - each node picks vectored or transfer service
// - vectored branches; transfer steals one cpu cycle
// - move byte or word, bump pointers
// - counter decrements per transfer except continuous mode
// - outside continuous mode, zero counter raises vectored interrupt instead
// - eight channels with own pointers, counter
// - node control: request, enable, priority
// - sixteen priority levels per node
// - only strictly higher level preempts cpu
// - each node owns its vector location
// - fast inputs: rising, falling or both edges
// - software trap number vectors to its location
// - software write sets request like hardware
// - vector offset is trap number times four, shifted left by the spacing field (times 4 to 32)
// - shared capture nodes take alternate request source
// - trap numbers grouped per peripheral block
// - vector segment register and spacing field
// - unlisted vectors never targeted by hardware
`timescale 1ns/1ps
module pie_top #(
  parameter int CHANS = pie_pkg::CHANS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [pie_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [pie_pkg::NODES-1:0] i_hw_req,
  input wire logic [pie_pkg::ALT_W-1:0] i_alt_req,
  input wire logic [pie_pkg::FAST_PINS-1:0] i_fast_pin,
  input wire logic [pie_pkg::LVL_W-1:0] i_cpu_level,
  input wire logic i_irq_ack,
  input wire logic i_trap_valid,
  input wire logic [pie_pkg::TRAP_W-1:0] i_trap_num,
  output logic o_irq_req,
  output logic [pie_pkg::TRAP_W-1:0] o_irq_trap,
  output logic [pie_pkg::LVL_W-1:0] o_irq_level,
  output logic [23:0] o_irq_vector,
  output logic o_sw_vec_valid,
  output logic [23:0] o_sw_vector,
  output logic o_xfer_valid,
  output logic [pie_pkg::PTR_W-1:0] o_xfer_src,
  output logic [pie_pkg::PTR_W-1:0] o_xfer_dst,
  output logic o_xfer_word,
  output logic o_cpu_stall
);
  localparam int N = pie_pkg::NODES;
  localparam int PW = pie_pkg::PTR_W;
  localparam int LW = pie_pkg::LVL_W;
  localparam int IW = pie_pkg::IDX_W;
  localparam int TW = pie_pkg::TRAP_W;

  if (CHANS < 1 || CHANS > (1 << pie_pkg::CTL_CH_W)) begin : g_chk
    $error("pie_top: channel count out of range");
  end

  typedef struct packed {
    logic [N-1:0][pie_pkg::CTL_W-1:0] ctl;
    logic [CHANS-1:0][PW-1:0] src;
    logic [CHANS-1:0][PW-1:0] dst;
    logic [CHANS-1:0][pie_pkg::CC_W-1:0] cc;
    logic [pie_pkg::SEG_W-1:0] seg;
    logic [pie_pkg::CFG_W-1:0] cfg;
    logic [pie_pkg::FAST_PINS*pie_pkg::FAST_FLD_W-1:0] fast;
    pie_pkg::pie_state_t st;
    logic [3:0] cnt;
    logic [IW-1:0] win;
    logic waitreq;
    logic [31:0] rdata;
    logic irq_req;
    logic [TW-1:0] trap;
    logic [LW-1:0] level;
    logic [23:0] vector;
    logic swv;
    logic [23:0] swvec;
    logic xv;
    logic [PW-1:0] xs;
    logic [PW-1:0] xd;
    logic xw;
    logic stall;
  } pie_top_st_t;

  pie_top_st_t r;
  pie_top_st_t n;

  logic [N-1:0] pend;
  logic [N-1:0][LW-1:0] lvls;
  logic [N-1:0] node_set;
  logic [N-1:0] fast_hit;
  logic [pie_pkg::FAST_PINS-1:0] fast_edge;
  logic [2*pie_pkg::FAST_PINS-1:0] fast_mode;
  logic win_v;
  logic [IW-1:0] win_idx;
  logic [LW-1:0] win_lvl;
  logic [31:0] rd;

  function automatic logic [15:0] vec_ofs(input logic [TW-1:0] trap, input logic [1:0] vsc);
    vec_ofs = {9'h000, trap} << (pie_pkg::VEC_BASE_SHIFT + int'(vsc));
  endfunction

  function automatic logic is_shared(input int t);
    is_shared = (t >= pie_pkg::SHARED_A_LO && t <= pie_pkg::SHARED_A_HI) ||
                (t >= pie_pkg::SHARED_B_LO && t <= pie_pkg::SHARED_B_HI);
  endfunction

  function automatic int alt_bit(input int t);
    alt_bit = (t <= pie_pkg::SHARED_A_HI) ? t - pie_pkg::SHARED_A_LO :
              t - pie_pkg::SHARED_B_LO + (pie_pkg::SHARED_A_HI - pie_pkg::SHARED_A_LO + 1);
  endfunction

  // per node: request source select, pending qualification
  // i_hw_req bit g is trap FIRST_TRAP+g, so the trap groups follow the bit order
  for (genvar g = 0; g < N; g++) begin : g_node
    localparam int T = pie_pkg::FIRST_TRAP + g;
    logic hw_src;
    if (is_shared(T)) begin : g_sh
      assign hw_src = r.ctl[g][pie_pkg::CTL_ALT_BIT] ? i_alt_req[alt_bit(T)] : i_hw_req[g];
    end else begin : g_pl
      assign hw_src = i_hw_req[g];
    end
    assign node_set[g] = hw_src | fast_hit[g];
    assign lvls[g] = r.ctl[g][pie_pkg::CTL_LVL_LSB +: LW];
    assign pend[g] = r.ctl[g][pie_pkg::CTL_IR_BIT] & r.ctl[g][pie_pkg::CTL_IE_BIT] &
                     (lvls[g] > i_cpu_level);
  end

  always_comb begin
    fast_hit = '0;
    for (int p = 0; p < pie_pkg::FAST_PINS; p++) begin
      fast_mode[2*p +: 2] = r.fast[p*pie_pkg::FAST_FLD_W + pie_pkg::FAST_MODE_LSB +: 2];
      if (r.fast[p*pie_pkg::FAST_FLD_W +: IW] < IW'(N)) begin
        fast_hit[r.fast[p*pie_pkg::FAST_FLD_W +: IW]] = fast_hit[r.fast[p*pie_pkg::FAST_FLD_W +: IW]] |
                                                         fast_edge[p];
      end
    end
  end

  pie_edge #(.W(pie_pkg::FAST_PINS)) u_edge (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_fast_pin),
    .i_mode(fast_mode),
    .o_edge(fast_edge)
  );

  pie_arb #(.N(N), .LW(LW), .IW(IW)) u_arb (
    .i_pend(pend),
    .i_lvl(lvls),
    .o_valid(win_v),
    .o_idx(win_idx),
    .o_lvl(win_lvl)
  );

  // register read mux
  always_comb begin
    logic [7:0] ofs;
    ofs = i_avs_address - pie_pkg::A_CH0;
    rd = '0;
    if (i_avs_address < 8'(N)) begin
      rd = {16'h0000, r.ctl[i_avs_address[IW-1:0]] & pie_pkg::CTL_MASK};
    end else if (i_avs_address == pie_pkg::A_SEG) begin
      rd = 32'(r.seg);
    end else if (i_avs_address == pie_pkg::A_CFG) begin
      rd = 32'(r.cfg);
    end else if (i_avs_address == pie_pkg::A_FAST) begin
      rd = r.fast;
    end else if (i_avs_address == pie_pkg::A_STAT) begin
      rd = 32'({win_v, r.win, r.cnt, r.st});
    end else if (i_avs_address >= pie_pkg::A_CH0 && ofs < 8'(pie_pkg::CH_STRIDE * CHANS)) begin
      case (ofs % 8'(pie_pkg::CH_STRIDE))
        8'h00: rd = 32'(r.src[ofs / 8'(pie_pkg::CH_STRIDE)]);
        8'h01: rd = 32'(r.dst[ofs / 8'(pie_pkg::CH_STRIDE)]);
        default: rd = 32'(r.cc[ofs / 8'(pie_pkg::CH_STRIDE)]);
      endcase
    end
  end

  always_comb begin
    logic [7:0] ofs;
    logic [N-1:0] clr;
    logic [pie_pkg::CTL_CH_W-1:0] ch;
    logic [pie_pkg::CC_CNT_W-1:0] tcnt;
    logic [PW-1:0] step;
    ofs = i_avs_address - pie_pkg::A_CH0;
    clr = '0;
    ch = '0;
    tcnt = '0;
    step = '0;
    n = r;
    n.swv = 1'b0;
    n.xv = 1'b0;
    n.stall = 1'b0;
    // avalon slave: one wait cycle, then answer
    n.waitreq = 1'b1;
    if ((i_avs_read || i_avs_write) && r.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = rd;
    end
    if (i_avs_write && !r.waitreq) begin
      if (i_avs_address < 8'(N)) begin
        n.ctl[i_avs_address[IW-1:0]] = i_avs_writedata[15:0] & pie_pkg::CTL_MASK;
      end else if (i_avs_address == pie_pkg::A_SEG) begin
        n.seg = i_avs_writedata[pie_pkg::SEG_W-1:0];
      end else if (i_avs_address == pie_pkg::A_CFG) begin
        n.cfg = i_avs_writedata[pie_pkg::CFG_W-1:0];
      end else if (i_avs_address == pie_pkg::A_FAST) begin
        n.fast = i_avs_writedata;
      end else if (i_avs_address >= pie_pkg::A_CH0 && ofs < 8'(pie_pkg::CH_STRIDE * CHANS)) begin
        case (ofs % 8'(pie_pkg::CH_STRIDE))
          8'h00: n.src[ofs / 8'(pie_pkg::CH_STRIDE)] = i_avs_writedata[PW-1:0];
          8'h01: n.dst[ofs / 8'(pie_pkg::CH_STRIDE)] = i_avs_writedata[PW-1:0];
          default: n.cc[ofs / 8'(pie_pkg::CH_STRIDE)] = i_avs_writedata[pie_pkg::CC_W-1:0];
        endcase
      end
    end
    // software trap
    if (i_trap_valid) begin
      n.swv = 1'b1;
      n.swvec = {r.seg, vec_ofs(i_trap_num, r.cfg[pie_pkg::CFG_VSC_LSB +: pie_pkg::CFG_VSC_W])};
    end
    // service sequencer
    case (r.st)
      pie_pkg::ST_IDLE: begin
        if (win_v) begin
          n.win = win_idx;
          ch = r.ctl[win_idx][pie_pkg::CTL_CH_LSB +: pie_pkg::CTL_CH_W];
          tcnt = r.cc[ch][pie_pkg::CC_CNT_LSB +: pie_pkg::CC_CNT_W];
          step = r.cc[ch][pie_pkg::CC_WORD_BIT] ? 16'h0002 : 16'h0001;
          if (r.ctl[win_idx][pie_pkg::CTL_XFER_BIT] && 32'(ch) < CHANS &&
              (tcnt != '0 || r.cc[ch][pie_pkg::CC_CONT_BIT])) begin
            n.st = pie_pkg::ST_XFER;
            n.xv = 1'b1;
            n.stall = 1'b1;
            n.xs = r.src[ch];
            n.xd = r.dst[ch];
            n.xw = r.cc[ch][pie_pkg::CC_WORD_BIT];
            if (r.cc[ch][pie_pkg::CC_INCS_BIT]) begin
              n.src[ch] = r.src[ch] + step;
            end
            if (r.cc[ch][pie_pkg::CC_INCD_BIT]) begin
              n.dst[ch] = r.dst[ch] + step;
            end
            if (!r.cc[ch][pie_pkg::CC_CONT_BIT]) begin
              n.cc[ch][pie_pkg::CC_CNT_LSB +: pie_pkg::CC_CNT_W] = tcnt - 8'h01;
            end
            clr[win_idx] = 1'b1;
          end else begin
            // vectored service, also taken when the channel counter is exhausted
            n.st = pie_pkg::ST_RESP;
            n.cnt = r.cfg[pie_pkg::CFG_JC_BIT] ? 4'(pie_pkg::RESP_JC_CLK - 2) :
                    4'(pie_pkg::RESP_NJC_CLK - 2);
            n.level = win_lvl;
            n.trap = TW'(pie_pkg::FIRST_TRAP) + TW'(win_idx);
            n.vector = {r.seg, vec_ofs(TW'(pie_pkg::FIRST_TRAP) + TW'(win_idx),
                                       r.cfg[pie_pkg::CFG_VSC_LSB +: pie_pkg::CFG_VSC_W])};
          end
        end
      end
      pie_pkg::ST_RESP: begin
        if (r.cnt == 4'h0) begin
          n.st = pie_pkg::ST_OFFER;
          n.irq_req = 1'b1;
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      pie_pkg::ST_OFFER: begin
        if (i_irq_ack) begin
          n.irq_req = 1'b0;
          clr[r.win] = 1'b1;
          n.st = pie_pkg::ST_IDLE;
        end
      end
      pie_pkg::ST_XFER: begin
        n.st = pie_pkg::ST_IDLE;
      end
      default: begin
        n.st = pie_pkg::ST_IDLE;
      end
    endcase
    // request flags: service clears, a new event in the same cycle wins
    for (int i = 0; i < N; i++) begin
      n.ctl[i][pie_pkg::CTL_IR_BIT] = (n.ctl[i][pie_pkg::CTL_IR_BIT] & ~clr[i]) | node_set[i];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.cfg <= pie_pkg::CFG_RST;
      r.st <= pie_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign o_avs_readdata = r.rdata;
  assign o_avs_waitrequest = r.waitreq;
  assign o_irq_req = r.irq_req;
  assign o_irq_trap = r.trap;
  assign o_irq_level = r.level;
  assign o_irq_vector = r.vector;
  assign o_sw_vec_valid = r.swv;
  assign o_sw_vector = r.swvec;
  assign o_xfer_valid = r.xv;
  assign o_xfer_src = r.xs;
  assign o_xfer_dst = r.xd;
  assign o_xfer_word = r.xw;
  assign o_cpu_stall = r.stall;
endmodule

// ===== test/pie_monitor.sv
// port assertions for the interrupt and transfer controller
// assumes it is bound to pie_top; one clock domain
`timescale 1ns/1ps
module pie_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [pie_pkg::LVL_W-1:0] i_cpu_level,
  input wire logic i_irq_ack,
  input wire logic i_trap_valid,
  input wire logic o_irq_req,
  input wire logic [pie_pkg::TRAP_W-1:0] o_irq_trap,
  input wire logic [pie_pkg::LVL_W-1:0] o_irq_level,
  input wire logic [23:0] o_irq_vector,
  input wire logic o_sw_vec_valid,
  input wire logic o_xfer_valid,
  input wire logic o_cpu_stall
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_wait_pulse;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_wait_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus request not answered");
  property p_xfer_pulse;
    o_xfer_valid |=> !o_xfer_valid;
  endproperty
  a_xfer_pulse: assert property (p_xfer_pulse) else $error("transfer longer than one cycle");
  property p_stall_pair;
    o_cpu_stall == o_xfer_valid;
  endproperty
  a_stall_pair: assert property (p_stall_pair) else $error("stall not paired with transfer");
  property p_no_branch;
    o_xfer_valid |-> !o_irq_req;
  endproperty
  a_no_branch: assert property (p_no_branch) else $error("transfer with interrupt offer");
  property p_hold;
    o_irq_req && !i_irq_ack |=> o_irq_req && $stable(o_irq_vector) && $stable(o_irq_trap);
  endproperty
  a_hold: assert property (p_hold) else $error("offer changed before ack");
  property p_drop;
    o_irq_req && i_irq_ack |=> !o_irq_req;
  endproperty
  a_drop: assert property (p_drop) else $error("offer kept after ack");
  property p_level;
    $rose(o_irq_req) |-> o_irq_level > i_cpu_level;
  endproperty
  a_level: assert property (p_level) else $error("offer not above cpu level");
  property p_range;
    o_irq_req |-> o_irq_trap inside {[16:67]};
  endproperty
  a_range: assert property (p_range) else $error("offer to unassigned trap");
  property p_sw;
    i_trap_valid |=> o_sw_vec_valid ##1 !o_sw_vec_valid;
  endproperty
  a_sw: assert property (p_sw) else $error("software vector pulse wrong");
endmodule
bind pie_top pie_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_cpu_level(i_cpu_level),
  .i_irq_ack(i_irq_ack), .i_trap_valid(i_trap_valid), .o_irq_req(o_irq_req), .o_irq_trap(o_irq_trap),
  .o_irq_level(o_irq_level), .o_irq_vector(o_irq_vector), .o_sw_vec_valid(o_sw_vec_valid),
  .o_xfer_valid(o_xfer_valid), .o_cpu_stall(o_cpu_stall));

// ===== test/pie_cpu_model.sv
// cpu side: accepts offered interrupts after a set delay, records what it took
// assumes an offer holds until acknowledged
`timescale 1ns/1ps
module pie_cpu_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [pie_pkg::TRAP_W-1:0] i_trap,
  input wire logic [23:0] i_vec,
  input wire logic [3:0] i_dly,
  output logic o_ack,
  output int o_n,
  output logic [pie_pkg::TRAP_W-1:0] o_trap,
  output logic [23:0] o_vec
);
  logic [3:0] cnt_r;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      cnt_r <= 4'h0;
      o_n <= 0;
      o_trap <= 7'h00;
      o_vec <= 24'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_req && o_ack) begin
        o_n <= o_n + 1;
        o_trap <= i_trap;
        o_vec <= i_vec;
        cnt_r <= 4'h0;
      end else if (i_req && cnt_r >= i_dly) begin
        o_ack <= 1'b1;
      end else if (i_req) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

// ===== test/pie_top_tb.sv
// self-checking bench for the interrupt and transfer controller
// assumes pie_cpu_model as cpu and pie_monitor bound to the design
`timescale 1ns/1ps
module pie_top_tb;
  logic clk = 0, rst = 1, rd_s = 0, wr_s = 0, tv = 0, ack, irq, swv, xv, xw, stall, wreq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, v;
  logic [51:0] hw = 52'h0;
  logic [9:0] alt = 10'h000;
  logic [3:0] fp = 4'h0, lvl = 4'h0, dly = 4'h0, ilvl;
  logic [6:0] tn = 7'h00, itrap, mtrap;
  logic [23:0] ivec, swvec, mvec;
  logic [15:0] xs, xd;
  int n_mismatch = 0, n_checks = 0, cyc = 0, mn = 0, k, nacc;
  pie_top uut (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_hw_req(hw), .i_alt_req(alt),
    .i_fast_pin(fp), .i_cpu_level(lvl), .i_irq_ack(ack), .i_trap_valid(tv), .i_trap_num(tn), .o_irq_req(irq),
    .o_irq_trap(itrap), .o_irq_level(ilvl), .o_irq_vector(ivec), .o_sw_vec_valid(swv), .o_sw_vector(swvec),
    .o_xfer_valid(xv), .o_xfer_src(xs), .o_xfer_dst(xd), .o_xfer_word(xw), .o_cpu_stall(stall));
  pie_cpu_model m (.i_sys_clk(clk), .i_rst(rst), .i_req(irq), .i_trap(itrap), .i_vec(ivec), .i_dly(dly),
    .o_ack(ack), .o_n(nacc), .o_trap(mtrap), .o_vec(mvec));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task tk;
    @(posedge clk);
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    tk;
    while (wreq !== 1'b0) begin
      tk;
    end
    v = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    tk;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e, "register");
  endtask
  task waitirq(input logic [6:0] t, input logic [23:0] vc);
    k = 0;
    while (nacc == mn && k < 80) begin
      tk;
      k++;
    end
    chk(mtrap, t, "trap");
    chk(mvec, vc, "vector");
    chk(nacc, mn + 1, "accepted");
    mn = nacc;
  endtask
  task pulse(input int i);
    hw[i] <= 1'b1;
    tk;
    hw[i] <= 1'b0;
  endtask
  task xwait;
    k = 0;
    while (xv !== 1'b1 && k < 20) begin
      tk;
      k++;
    end
    chk(stall, 1, "stall");
  endtask
  // offer is seen at the edge after the one that raises it
  task lat(input int e, input logic [3:0] lv, input string nm);
    k = 0;
    while (irq !== 1'b1) begin
      tk;
      k++;
    end
    chk(k, e + 1, nm);
    chk(ilvl, lv, "level");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    chk(wreq, 1, "wait_in_reset");
    rst <= 1'b0;
    tk;
    rchk(8'h00, 0);
    rchk(8'h41, 0);
    rchk(8'h53, 0);
    bus(1'b1, 8'h44, 32'hffff);
    rchk(8'h44, 0);
    bus(1'b1, 8'h00, 32'h3e0f);
    rchk(8'h00, 32'h000f);
    bus(1'b1, 8'h04, 32'h4005);
    bus(1'b1, 8'h18, 32'h4009);
    bus(1'b1, 8'h19, 32'h4009);
    hw <= 52'h0000003000010;
    tk;
    hw <= 52'h0;
    lat(pie_pkg::RESP_NJC_CLK, 4'h9, "latency_plain");
    waitirq(40, 24'h0000a0);
    waitirq(41, 24'h0000a4);
    waitirq(20, 24'h000050);
    bus(1'b1, 8'h41, 32'h4);
    pulse(4);
    lat(pie_pkg::RESP_JC_CLK, 4'h5, "latency_cache");
    waitirq(20, 24'h000050);
    dly <= 4'h3;
    lvl <= 4'h5;
    pulse(4);
    repeat (20) tk;
    chk(irq, 0, "equal_level");
    lvl <= 4'h0;
    waitirq(20, 24'h000050);
    bus(1'b1, 8'h05, 32'hc003);
    waitirq(21, 24'h000054);
    rchk(8'h05, 32'h4003);
    bus(1'b1, 8'h02, 32'h4101);
    alt <= 10'h001;
    tk;
    alt <= 10'h000;
    waitirq(18, 24'h000048);
    bus(1'b1, 8'h40, 32'h12);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h41, s);
      tn <= 7'd100;
      tv <= 1'b1;
      tk;
      tv <= 1'b0;
      tk;
      chk(swv, 1, "sw_valid");
      chk(swvec, {8'h12, 16'd100 << (2 + s)}, "sw_vector");
    end
    bus(1'b1, 8'h41, 32'h1);
    pulse(4);
    waitirq(20, 24'h1200a0);
    bus(1'b1, 8'h41, 32'h0);
    bus(1'b1, 8'h51, 32'h1000);
    bus(1'b1, 8'h52, 32'h2000);
    bus(1'b1, 8'h53, 32'h702);
    bus(1'b1, 8'h11, 32'h4073);
    for (int i = 0; i < 2; i++) begin
      pulse(17);
      xwait;
      chk(xs, 32'h1000 + 2 * i, "src");
      chk(xd, 32'h2000 + 2 * i, "dst");
      chk(xw, 1, "word");
    end
    rchk(8'h53, 32'h700);
    pulse(17);
    waitirq(33, 24'h120084);
    rchk(8'h51, 32'h1004);
    bus(1'b1, 8'h53, 32'ha00);
    for (int i = 0; i < 2; i++) begin
      pulse(17);
      xwait;
      chk(xs, 32'h1004 + i, "src_byte");
      chk(xd, 32'h2004, "dst_fixed");
      chk(xw, 0, "byte");
    end
    rchk(8'h53, 32'ha00);
    bus(1'b1, 8'h00, 32'h4001);
    for (int md = 0; md < 4; md++) begin
      bus(1'b1, 8'h42, md << 6);
      fp <= 4'h1;
      repeat (30) tk;
      chk(nacc - mn, md & 1, "fast_rise");
      mn = nacc;
      fp <= 4'h0;
      repeat (30) tk;
      chk(nacc - mn, md >> 1, "fast_fall");
      mn = nacc;
    end
    summarize;
  end
endmodule
